// ===== pom_pkg.sv
/*
 * constants for the protection output matrix and trip latch.
 * assumes stage start/trip levels come from logic on the same clock.
 */
`default_nettype none

package pom_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [3:0] ADDR_MATRIX_MAIN  = 4'h0;
	localparam logic [3:0] ADDR_MATRIX_SIG   = 4'h1;
	localparam logic [3:0] ADDR_MATRIX_AUX   = 4'h2;
	localparam logic [3:0] ADDR_BLOCK_LATCH  = 4'h3;
	localparam logic [3:0] ADDR_FUNC_CTRL    = 4'h4;
	localparam logic [3:0] ADDR_STATUS       = 4'h5;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] RST_MATRIX_MAIN   = 8'hab;
	localparam logic [7:0] RST_MATRIX_SIG    = 8'ha5;
	localparam logic [7:0] RST_MATRIX_AUX    = 8'h00;
	localparam logic [7:0] RST_BLOCK_LATCH   = 8'h00;
	localparam logic [7:0] RST_FUNC_CTRL     = 8'h00;

	// ****************************************
	// field positions
	// ****************************************
	localparam int BLK_OC_LATCH_SEL   = 5;
	localparam int BLK_EF_LATCH_SEL   = 6;
	localparam int BLK_REMOTE_RST_EN  = 7;
	localparam int CTL_BREAKER_FAIL   = 0;
	localparam int CTL_AUTORECLOSE    = 1;
	localparam logic [3:0] OC_STAGES  = 4'h3;
	localparam logic [3:0] EF_STAGES  = 4'hc;
	localparam int STG_OC_HIGH        = 1;
endpackage : pom_pkg

`default_nettype wire

// ===== pom_matrix_latch.sv
/*
 * output matrix and trip latch for four protection stages.
 * assumes stage levels and breaker-failure trip are on i_mclk; buttons
 * and the external control input are asynchronous pins.
 */
`default_nettype none

module pom_matrix_latch #(
	parameter bit P_PROG_ALONE_RESET = 1'b1
) (
	input  wire logic       i_mclk,
	input  wire logic       i_srst,
	input  wire logic [3:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	input  wire logic [3:0] i_stage_start,
	input  wire logic [3:0] i_stage_trip,
	input  wire logic       i_breaker_fail_trip,
	input  wire logic       i_btn_reset,
	input  wire logic       i_btn_program,
	input  wire logic       i_external_control_input,
	output logic            o_start_output_one,
	output logic            o_signal_output_two,
	output logic            o_signal_output_three,
	output logic            o_aux_trip_output,
	output logic            o_main_trip_output,
	output logic            o_autoreclose_output_one
);

	// ****************************************
	// helpers
	// ****************************************
	// or over stages whose switch is set; odd switch = even bit index
	function automatic logic pom_route(input logic [3:0] src, input logic [7:0] mtx,
		input logic odd_sw);
		logic acc;
		acc = 1'b0;
		for (int k = 0; k < 4; k++)
		begin
			acc = acc | (src[k] & mtx[2*k + (odd_sw ? 0 : 1)]);
		end
		return acc;
	endfunction

	// switch n weighs 2**(n-1)
	function automatic logic [7:0] pom_checksum(input logic [7:0] grp);
		logic [7:0] sum;
		sum = 8'h00;
		for (int n = 0; n < 8; n++)
		begin
			if (grp[n])
			begin
				sum = sum + 8'(1 << n);
			end
		end
		return sum;
	endfunction

	// ****************************************
	// registers
	// ****************************************
	logic [7:0] matrix_main_r;
	logic [7:0] matrix_sig_r;
	logic [7:0] matrix_aux_r;
	logic [7:0] block_latch_r;
	logic [7:0] func_ctrl_r;
	logic [7:0] status_nxt;
	logic [7:0] rdata_nxt;

	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
		begin
			matrix_main_r <= pom_pkg::RST_MATRIX_MAIN;
			matrix_sig_r  <= pom_pkg::RST_MATRIX_SIG;
			matrix_aux_r  <= pom_pkg::RST_MATRIX_AUX;
			block_latch_r <= pom_pkg::RST_BLOCK_LATCH;
			func_ctrl_r   <= pom_pkg::RST_FUNC_CTRL;
		end
		else if (i_wr)
		begin
			case (i_addr)
				pom_pkg::ADDR_MATRIX_MAIN: matrix_main_r <= i_wdata;
				pom_pkg::ADDR_MATRIX_SIG:  matrix_sig_r  <= i_wdata;
				pom_pkg::ADDR_MATRIX_AUX:  matrix_aux_r  <= i_wdata;
				pom_pkg::ADDR_BLOCK_LATCH: block_latch_r <= i_wdata;
				pom_pkg::ADDR_FUNC_CTRL:   func_ctrl_r   <= i_wdata;
				default: ;
			endcase
		end
	end

	// matrix groups read back as their checksum
	always_comb
	begin
		rdata_nxt = 8'h00;
		if (i_rd)
		begin
			case (i_addr)
				pom_pkg::ADDR_MATRIX_MAIN: rdata_nxt = pom_checksum(matrix_main_r);
				pom_pkg::ADDR_MATRIX_SIG:  rdata_nxt = pom_checksum(matrix_sig_r);
				pom_pkg::ADDR_MATRIX_AUX:  rdata_nxt = pom_checksum(matrix_aux_r);
				pom_pkg::ADDR_BLOCK_LATCH: rdata_nxt = pom_checksum(block_latch_r);
				pom_pkg::ADDR_FUNC_CTRL:   rdata_nxt = func_ctrl_r;
				pom_pkg::ADDR_STATUS:      rdata_nxt = status_nxt;
				default:                   rdata_nxt = 8'h00;
			endcase
		end
	end

	// read data stands one cycle only, zero otherwise
	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
			o_rdata <= 8'h00;
		else
			o_rdata <= rdata_nxt;
	end

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [2:0] pin_meta_r;
	logic [2:0] pin_sync_r;

	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
		begin
			pin_meta_r <= 3'h0;
			pin_sync_r <= 3'h0;
		end
		else
		begin
			pin_meta_r <= {i_external_control_input, i_btn_program, i_btn_reset};
			pin_sync_r <= pin_meta_r;
		end
	end

	logic btn_reset_s;
	logic btn_prog_s;
	logic ext_ctrl_s;
	assign btn_reset_s = pin_sync_r[0];
	assign btn_prog_s  = pin_sync_r[1];
	assign ext_ctrl_s  = pin_sync_r[2];

	// ****************************************
	// routing
	// ****************************************
	logic oc_sel;
	logic ef_sel;
	logic oc_trip;
	logic ef_trip;
	logic ar_start;
	logic start_one_nxt;
	logic sig_two_nxt;
	logic sig_three_nxt;
	logic aux_nxt;

	assign oc_sel  = block_latch_r[pom_pkg::BLK_OC_LATCH_SEL];
	assign ef_sel  = block_latch_r[pom_pkg::BLK_EF_LATCH_SEL];
	assign oc_trip = pom_route(i_stage_trip & pom_pkg::OC_STAGES, matrix_main_r, 1'b0);
	assign ef_trip = pom_route(i_stage_trip & pom_pkg::EF_STAGES, matrix_main_r, 1'b0);
	assign ar_start = func_ctrl_r[pom_pkg::CTL_AUTORECLOSE]
		& i_stage_start[pom_pkg::STG_OC_HIGH];

	always_comb
	begin
		start_one_nxt = pom_route(i_stage_start, matrix_main_r, 1'b1);
		sig_two_nxt   = pom_route(i_stage_trip, matrix_sig_r, 1'b1);
		// shared with the auto-reclose output; software keeps it free
		sig_three_nxt = pom_route(i_stage_trip, matrix_sig_r, 1'b0) | ar_start;
		aux_nxt       = pom_route(i_stage_start, matrix_aux_r, 1'b1)
			| pom_route(i_stage_trip, matrix_aux_r, 1'b0)
			| (func_ctrl_r[pom_pkg::CTL_BREAKER_FAIL] & i_breaker_fail_trip);
	end

	// ****************************************
	// trip latch
	// ****************************************
	logic oc_latch_r;
	logic ef_latch_r;
	logic latch_clr;

	// records live elsewhere; this clear touches only the latch
	assign latch_clr = (btn_reset_s & btn_prog_s)
		| (P_PROG_ALONE_RESET & btn_prog_s)
		| (ext_ctrl_s & block_latch_r[pom_pkg::BLK_REMOTE_RST_EN]);

	// a trip in the clear cycle wins, so no fault is lost
	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
			oc_latch_r <= 1'b0;
		else if (!oc_sel)
			oc_latch_r <= 1'b0;
		else if (oc_trip)
			oc_latch_r <= 1'b1;
		else if (latch_clr)
			oc_latch_r <= 1'b0;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
			ef_latch_r <= 1'b0;
		else if (!ef_sel)
			ef_latch_r <= 1'b0;
		else if (ef_trip)
			ef_latch_r <= 1'b1;
		else if (latch_clr)
			ef_latch_r <= 1'b0;
	end

	// ****************************************
	// output flops
	// ****************************************
	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
		begin
			o_start_output_one       <= 1'b0;
			o_signal_output_two      <= 1'b0;
			o_signal_output_three    <= 1'b0;
			o_aux_trip_output        <= 1'b0;
			o_main_trip_output       <= 1'b0;
			o_autoreclose_output_one <= 1'b0;
		end
		else
		begin
			o_start_output_one       <= start_one_nxt;
			o_signal_output_two      <= sig_two_nxt;
			o_signal_output_three    <= sig_three_nxt;
			o_aux_trip_output        <= aux_nxt;
			// latch state holds the output on after the live trip is gone
			o_main_trip_output       <= oc_trip | ef_trip | oc_latch_r | ef_latch_r;
			o_autoreclose_output_one <= ar_start;
		end
	end

	assign status_nxt = {ef_latch_r, oc_latch_r, o_autoreclose_output_one,
		o_main_trip_output, o_aux_trip_output, o_signal_output_three,
		o_signal_output_two, o_start_output_one};

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_srst);

	logic any_latch;
	assign any_latch = oc_latch_r | ef_latch_r;

	sequence s_held;
		any_latch && !oc_trip && !ef_trip;
	endsequence

	sequence s_clear_req;
		s_held ##0 latch_clr;
	endsequence

	a_factory_values: assert property (
		$past(i_srst) && !$past(i_wr) |-> matrix_main_r == 8'hab
			&& matrix_sig_r == 8'ha5 && matrix_aux_r == 8'h00
			&& block_latch_r == 8'h00)
		else $error("registers lost factory values");

	a_checksum_read: assert property (
		i_rd && i_addr == pom_pkg::ADDR_MATRIX_SIG |=> o_rdata == $past(matrix_sig_r))
		else $error("checksum read wrong");

	a_start_one: assert property (
		i_stage_start[0] && matrix_main_r[0] |=> o_start_output_one)
		else $error("start output one not driven");

	a_main_trip_route: assert property (
		i_stage_trip[3] && matrix_main_r[7] |=> o_main_trip_output)
		else $error("main trip not driven");

	a_sig_outputs: assert property (
		i_stage_trip[2] && matrix_sig_r[4] && !matrix_sig_r[5] && !ar_start
			&& !(|(i_stage_trip & 4'hb))
		|=> o_signal_output_two && !o_signal_output_three)
		else $error("signal routing wrong");

	a_autoreclose: assert property (
		func_ctrl_r[pom_pkg::CTL_AUTORECLOSE] && i_stage_start[1]
		|=> o_signal_output_three && o_autoreclose_output_one)
		else $error("auto-reclose start not routed");

	a_aux_sources: assert property (
		(func_ctrl_r[pom_pkg::CTL_BREAKER_FAIL] && i_breaker_fail_trip)
			|| (i_stage_trip[1] && matrix_aux_r[3])
		|=> o_aux_trip_output)
		else $error("aux trip not driven");

	a_aux_quiet: assert property (
		matrix_aux_r == 8'h00 && !func_ctrl_r[pom_pkg::CTL_BREAKER_FAIL]
		|=> !o_aux_trip_output)
		else $error("aux trip driven with empty group");

	a_dropout: assert property (
		!oc_sel && !ef_sel && !oc_trip && !ef_trip |=> !o_main_trip_output)
		else $error("main trip failed to drop out");

	a_latch_holds: assert property (
		s_held ##0 !latch_clr && oc_sel && ef_sel |=> ##1 o_main_trip_output)
		else $error("held trip dropped without clear");

	a_ef_latch_set: assert property (
		ef_sel && ef_trip |=> ef_latch_r ##1 (o_main_trip_output || latch_clr))
		else $error("earth-fault latch not set");

	a_button_clear: assert property (
		s_held ##0 btn_prog_s && (btn_reset_s || P_PROG_ALONE_RESET)
		|=> !any_latch)
		else $error("button clear ignored");

	a_remote_clear: assert property (
		s_held ##0 ext_ctrl_s && block_latch_r[pom_pkg::BLK_REMOTE_RST_EN]
		|=> !any_latch)
		else $error("remote clear ignored");

	a_clear_drops: assert property (
		s_clear_req ##1 (!oc_trip && !ef_trip) |=> !o_main_trip_output)
		else $error("main trip stayed after clear");

	a_rdata_idle: assert property (
		!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside read slot");

	// outputs and latch come out of reset quiet, whatever was held before
	a_reset_outputs: assert property (
		$past(i_srst) |-> !o_main_trip_output && !o_aux_trip_output
			&& !o_start_output_one && !any_latch && o_rdata == 8'h00)
		else $error("outputs not quiet after reset");

endmodule // pom_matrix_latch

`default_nettype wire

// ===== pom_far_side.sv
/*
 * far side model: front-panel buttons and the remote control pin.
 * assumes the bench commands presses on the same clock.
 */
`default_nettype none

module pom_far_side (
	input  wire logic       i_mclk,
	input  wire logic [2:0] i_press,
	output logic            o_btn_reset = 1'b0,
	output logic            o_btn_program = 1'b0,
	output logic            o_ext_ctrl = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// contacts move off the edge: the design must sync them
	always @(negedge i_mclk)
	begin
		o_btn_reset   <= i_press[0];
		o_btn_program <= i_press[1];
		o_ext_ctrl    <= i_press[2];
	end
endmodule // pom_far_side

`default_nettype wire

// ===== pom_matrix_latch_bench.sv
/*
 * self-checking bench for the output matrix and trip latch.
 * assumes registered outputs one cycle after stage inputs.
 */
`default_nettype none

module pom_matrix_latch_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [7:0] m, s, a, f;
		logic [3:0] st, tr;
		logic       bf;
		logic [5:0] ex;
	} pom_row_t;
	logic       i_mclk = 1'b0;
	logic       i_srst = 1'b1;
	logic [3:0] i_addr = 4'h0;
	logic [7:0] i_wdata = 8'h00;
	logic       i_wr = 1'b0;
	logic       i_rd = 1'b0;
	logic [7:0] o_rdata;
	logic [3:0] i_stage_start = 4'h0;
	logic [3:0] i_stage_trip = 4'h0;
	logic       i_breaker_fail_trip = 1'b0;
	logic [2:0] press = 3'h0;
	logic       btn_rst, btn_prg, ext_ctl;
	wire  [5:0] outs;
	logic [7:0] rd_val;
	int         err_total = 0;
	int         tests_run = 0;
	pom_row_t   rows [10];

	initial
	begin
		forever #5 i_mclk = ~i_mclk;
	end

	pom_far_side i_pom_far_side (
		.i_mclk        (i_mclk),
		.i_press       (press),
		.o_btn_reset   (btn_rst),
		.o_btn_program (btn_prg),
		.o_ext_ctrl    (ext_ctl)
	);

	pom_matrix_latch i_pom_matrix_latch (
		.i_mclk                   (i_mclk),
		.i_srst                   (i_srst),
		.i_addr                   (i_addr),
		.i_wdata                  (i_wdata),
		.i_wr                     (i_wr),
		.i_rd                     (i_rd),
		.o_rdata                  (o_rdata),
		.i_stage_start            (i_stage_start),
		.i_stage_trip             (i_stage_trip),
		.i_breaker_fail_trip      (i_breaker_fail_trip),
		.i_btn_reset              (btn_rst),
		.i_btn_program            (btn_prg),
		.i_external_control_input (ext_ctl),
		.o_start_output_one       (outs[0]),
		.o_signal_output_two      (outs[1]),
		.o_signal_output_three    (outs[2]),
		.o_aux_trip_output        (outs[3]),
		.o_main_trip_output       (outs[4]),
		.o_autoreclose_output_one (outs[5])
	);

	// ****************************************
	// checks and bus tasks
	// ****************************************
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: register read %h, wanted %h", $time, got, exp);
		end
	endtask

	task automatic chk_out(input logic [5:0] got, input logic [5:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: outputs %b, wanted %b", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr    <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge i_mclk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd   <= 1'b0;
		#1 rd_val = o_rdata;
	endtask

	task automatic drive(input logic [3:0] st, input logic [3:0] tr, input logic bf);
		@(posedge i_mclk);
		i_stage_start       <= st;
		i_stage_trip        <= tr;
		i_breaker_fail_trip <= bf;
		repeat (2) @(posedge i_mclk);
		#1;
	endtask

	// trip, drop the trip, check hold, press, check after release
	task automatic latch_case(input logic [7:0] blk, input logic [3:0] tr,
		input logic [2:0] p, input logic hold, input logic after);
		wr(4'h3, blk);
		drive(4'h0, tr, 1'b0);
		drive(4'h0, 4'h0, 1'b0);
		chk_out({1'b0, outs[4], 4'h0}, {1'b0, hold, 4'h0});
		@(posedge i_mclk);
		press <= p;
		repeat (8) @(posedge i_mclk);
		press <= 3'h0;
		repeat (8) @(posedge i_mclk);
		#1 chk_out({1'b0, outs[4], 4'h0}, {1'b0, after, 4'h0});
	endtask

	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (5000) @(posedge i_mclk);
		err_total++;
		report_and_stop;
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		rows = '{
			'{8'hab, 8'ha5, 8'h00, 8'h00, 4'hf, 4'h0, 1'b0, 6'h01},
			'{8'hab, 8'ha5, 8'h00, 8'h00, 4'h0, 4'h8, 1'b0, 6'h14},
			'{8'hab, 8'ha5, 8'h00, 8'h00, 4'h0, 4'h1, 1'b0, 6'h12},
			'{8'h00, 8'h00, 8'hff, 8'h00, 4'h2, 4'h0, 1'b0, 6'h08},
			'{8'h00, 8'h00, 8'h00, 8'h01, 4'h0, 4'h0, 1'b1, 6'h08},
			'{8'h00, 8'h00, 8'h00, 8'h00, 4'h0, 4'h0, 1'b1, 6'h00},
			'{8'h00, 8'h00, 8'h00, 8'h02, 4'h2, 4'h0, 1'b0, 6'h24},
			'{8'h44, 8'h00, 8'h00, 8'h00, 4'h8, 4'h0, 1'b0, 6'h01},
			'{8'h00, 8'h02, 8'h00, 8'h00, 4'h0, 4'h1, 1'b0, 6'h04},
			'{8'h00, 8'h10, 8'h00, 8'h00, 4'h0, 4'h4, 1'b0, 6'h02}};
		repeat (4) @(posedge i_mclk);
		i_srst <= 1'b0;
		foreach (rows[k])
		begin
			if (k == 0)
			begin
				rd(4'h0); chk_reg(rd_val, 8'hab);
				rd(4'h1); chk_reg(rd_val, 8'ha5);
				rd(4'h2); chk_reg(rd_val, 8'h00);
				rd(4'h3); chk_reg(rd_val, 8'h00);
				rd(4'h9); chk_reg(rd_val, 8'h00);
			end
			wr(4'h0, rows[k].m);
			wr(4'h1, rows[k].s);
			wr(4'h2, rows[k].a);
			wr(4'h4, rows[k].f);
			drive(rows[k].st, rows[k].tr, rows[k].bf);
			chk_out(outs, rows[k].ex);
			rd(4'h0); chk_reg(rd_val, rows[k].m);
			rd(4'h1); chk_reg(rd_val, rows[k].s);
			rd(4'h4);
			chk_reg(rd_val, rows[k].f);
		end
		wr(4'h0, 8'hab);
		latch_case(8'h00, 4'h4, 3'h0, 1'b0, 1'b0);
		latch_case(8'h40, 4'h4, 3'h2, 1'b1, 1'b0);
		latch_case(8'h40, 4'h8, 3'h3, 1'b1, 1'b0);
		latch_case(8'h20, 4'h1, 3'h4, 1'b1, 1'b1);
		latch_case(8'ha0, 4'h2, 3'h4, 1'b1, 1'b0);
		latch_case(8'h40, 4'h1, 3'h0, 1'b0, 1'b0);
		latch_case(8'h20, 4'h4, 3'h0, 1'b0, 1'b0);
		// both selects on: reset button alone must not clear the hold
		latch_case(8'h60, 4'h4, 3'h1, 1'b1, 1'b1);
		rd(4'h5);
		chk_reg(rd_val, 8'h90);
		// mid-run reset drops the held trip and restores factory values
		@(posedge i_mclk);
		i_srst <= 1'b1;
		repeat (4) @(posedge i_mclk);
		i_srst <= 1'b0;
		rd(4'h0);
		chk_reg(rd_val, 8'hab);
		rd(4'h3);
		chk_reg(rd_val, 8'h00);
		chk_out(outs, 6'h00);
		latch_case(8'h60, 4'h8, 3'h3, 1'b1, 1'b0);
		report_and_stop;
	end
endmodule // pom_matrix_latch_bench

`default_nettype wire
